//--- hdl/ccdp_pkg.sv
// Package of constants and types for the configuration clock and data pins.
package ccdp_pkg;

  // --------------------------------------------------------------------------
  // Scheme encoding
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    CCDP_HOST_BIT  = 2'h0,
    CCDP_HOST_BYTE = 2'h1,
    CCDP_SELF_SER  = 2'h2,
    CCDP_SELF_PAR  = 2'h3
  } ccdp_scheme_t;

  // --------------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------------
  localparam int CCDP_CLK_MHZ     = 100;
  localparam int CCDP_PACE_NS     = 40;
  localparam int CCDP_PACE_CYC    = (CCDP_PACE_NS * CCDP_CLK_MHZ) / 1000;
  localparam int CCDP_HALF_CYC    = (CCDP_PACE_CYC / 2 < 1) ? 1
                                    : CCDP_PACE_CYC / 2;
  localparam logic CCDP_CLK_IDLE  = 1'b1;
  localparam int CCDP_BUS_W       = 16;
  localparam int CCDP_BYTE_W      = 8;

  // Drive of one two-way pin: output value and output enable.
  typedef struct packed {
    logic o;
    logic oe;
  } ccdp_pin_drv_t;

endpackage

//--- hdl/ccdp_top.sv
// Configuration clock and low data pin control for four loading schemes.
`timescale 1ns/100ps
// Function
// - Host-driven schemes: host clocks, device captures data on rising edge.
// - Self-timed serial: device drives the configuration clock as output.
// - Self-timed parallel: device drives the configuration clock as output.
// - Self-timed schemes drive the clock pin inactive after completion.
// - Self-timed schemes may release clock pin to user I/O in user mode.
// - Host-driven schemes: clock pin stays dedicated input, never user I/O.
// - Once configured, clock pin transitions are ignored; config unchanged.
// - Serial schemes: one bit per clock on data pin zero as input.
// - After self-timed serial, data pin zero is input with user control.
// - After host-driven schemes, data pin zero becomes dual-purpose user I/O.
// - After self-timed parallel, data pin zero is user-controlled two-way.
// - Self-timed serial drives data pin one to flash; otherwise no output.
// - After self-timed serial, data pin one is user-controlled output.
// - Host bit-serial: data pin one is user I/O, tri-stated in loading.
// - After host byte-parallel, data pin one becomes dual-purpose user I/O.
// - Self-timed parallel: flash gives byte or word per transfer.
// - After self-timed parallel, data pin one is user-controlled two-way.
// - Done line low before and during loading, released on success.

module ccdp_top
  import ccdp_pkg::*;
#(
  parameter int BUS_W    = CCDP_BUS_W,
  parameter int BYTE_W   = CCDP_BYTE_W
)(
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic               link_clk,
  input  wire logic [1:0]         scheme_sel,
  input  wire logic               flash_word_mode,
  input  wire logic               chip_select_b,
  input  wire logic               load_start,
  input  wire logic               load_ok,
  input  wire logic               clk_pin_user_en,
  input  wire logic               config_clock_pin_i,
  output logic                    config_clock_pin_o,
  output logic                    config_clock_pin_oe,
  input  wire logic [1:0]         data_pin_i,
  output logic [1:0]              data_pin_o,
  output logic [1:0]              data_pin_oe,
  input  wire logic [BUS_W-1:0]   flash_bus_i,
  input  wire logic               serial_flash_command_out_d,
  input  wire logic               user_clk_o,
  input  wire logic               user_clk_oe,
  input  wire logic [1:0]         user_data_o,
  input  wire logic [1:0]         user_data_oe,
  output logic [1:0]              user_data_i,
  output logic                    config_complete_line_o,
  output logic                    config_complete_line_oe,
  output logic                    user_mode,
  output logic [BUS_W-1:0]        cfg_word,
  output logic                    cfg_word_valid,
  output logic                    cfg_word_is_wide,
  output ccdp_scheme_t            active_scheme
);

  // --------------------------------------------------------------------------
  // Phase machine
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    CCDP_IDLE = 3'h1,
    CCDP_LOAD = 3'h2,
    CCDP_USER = 3'h4
  } ccdp_phase_t;

  function automatic logic is_self_timed(input ccdp_scheme_t s);
    is_self_timed = (s == CCDP_SELF_SER) || (s == CCDP_SELF_PAR);
  endfunction

  function automatic logic is_serial(input ccdp_scheme_t s);
    is_serial = (s == CCDP_HOST_BIT) || (s == CCDP_SELF_SER);
  endfunction

  ccdp_phase_t   phase_q, phase_d;
  ccdp_scheme_t  scheme_q, scheme_d;
  logic          wide_q, wide_d;
  logic          cs_m_q, cs_q;
  logic          start_m_q, start_q;
  logic          ok_m_q, ok_q;

  always_comb
  begin
    phase_d  = phase_q;
    scheme_d = scheme_q;
    wide_d   = wide_q;
    case (phase_q)
      CCDP_IDLE:
      begin
        // The scheme is latched only here and held through loading.
        if (start_q && !cs_q)
        begin
          scheme_d = ccdp_scheme_t'(scheme_sel);
          wide_d   = flash_word_mode;
          phase_d  = CCDP_LOAD;
        end
      end
      CCDP_LOAD:
      begin
        if (cs_q)
          phase_d = CCDP_IDLE;
        else if (ok_q)
          phase_d = CCDP_USER;
      end
      CCDP_USER:
        phase_d = CCDP_USER;
      default:
        phase_d = CCDP_IDLE;
    endcase
  end

  // Chip select, start and load_ok come from pins, so each passes two
  // flip-flops before the phase logic reads it.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cs_m_q    <= 1'b1;
      cs_q      <= 1'b1;
      start_m_q <= 1'b0;
      start_q   <= 1'b0;
      ok_m_q    <= 1'b0;
      ok_q      <= 1'b0;
      phase_q   <= CCDP_IDLE;
      scheme_q  <= CCDP_HOST_BIT;
      wide_q    <= 1'b0;
    end
    else
    begin
      cs_m_q    <= chip_select_b;
      cs_q      <= cs_m_q;
      start_m_q <= load_start;
      start_q   <= start_m_q;
      ok_m_q    <= load_ok;
      ok_q      <= ok_m_q;
      phase_q   <= phase_d;
      scheme_q  <= scheme_d;
      wide_q    <= wide_d;
    end
  end

  // --------------------------------------------------------------------------
  // Load window
  // --------------------------------------------------------------------------
  logic loading;

  assign loading = (phase_q == CCDP_LOAD);

  // --------------------------------------------------------------------------
  // Self-timed clock generator
  // --------------------------------------------------------------------------
  logic [7:0] div_q, div_d;
  logic       gen_clk_q, gen_clk_d;

  always_comb
  begin
    div_d     = div_q;
    gen_clk_d = gen_clk_q;
    if (loading && is_self_timed(scheme_q))
    begin
      if (div_q == 8'(CCDP_HALF_CYC - 1))
      begin
        div_d     = 8'h00;
        gen_clk_d = ~gen_clk_q;
      end
      else
        div_d = div_q + 8'h01;
    end
    else
    begin
      div_d     = 8'h00;
      gen_clk_d = CCDP_CLK_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      div_q     <= 8'h00;
      gen_clk_q <= CCDP_CLK_IDLE;
    end
    else
    begin
      div_q     <= div_d;
      gen_clk_q <= gen_clk_d;
    end
  end

  // --------------------------------------------------------------------------
  // Link-domain capture on the rising clock edge
  // --------------------------------------------------------------------------
  logic             load_lk_m_q, load_lk_q;
  logic [BUS_W-1:0] cap_q, cap_d;
  logic             cap_tgl_q, cap_tgl_d;

  always_comb
  begin
    cap_d     = cap_q;
    cap_tgl_d = cap_tgl_q;
    if (load_lk_q)
    begin
      if (is_serial(scheme_q))
        cap_d = {{(BUS_W-1){1'b0}}, data_pin_i[0]};
      else if (scheme_q == CCDP_SELF_PAR && !wide_q)
        cap_d = {{(BUS_W-BYTE_W){1'b0}}, flash_bus_i[BYTE_W-1:0]};
      else
        cap_d = flash_bus_i;
      cap_tgl_d = ~cap_tgl_q;
    end
  end

  // The loading level crosses over through two flip-flops; the link clock may
  // stop at any time, so this gate can lag and the system side gates too.
  always_ff @(posedge link_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      load_lk_m_q <= 1'b0;
      load_lk_q   <= 1'b0;
      cap_q       <= '0;
      cap_tgl_q   <= 1'b0;
    end
    else
    begin
      load_lk_m_q <= loading;
      load_lk_q   <= load_lk_m_q;
      cap_q       <= cap_d;
      cap_tgl_q   <= cap_tgl_d;
    end
  end

  // Toggle handshake: the word is stable for several system cycles per beat.
  logic             tgl_m_q, tgl_q, tgl_r_q;
  logic [BUS_W-1:0] word_q, word_d;
  logic             wvalid_q, wvalid_d;

  always_comb
  begin
    word_d   = word_q;
    wvalid_d = 1'b0;
    // Beats that arrive outside the load window are dropped.
    if ((tgl_q != tgl_r_q) && (phase_d == CCDP_LOAD))
    begin
      word_d   = cap_q;
      wvalid_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tgl_m_q  <= 1'b0;
      tgl_q    <= 1'b0;
      tgl_r_q  <= 1'b0;
      word_q   <= '0;
      wvalid_q <= 1'b0;
    end
    else
    begin
      tgl_m_q  <= cap_tgl_q;
      tgl_q    <= tgl_m_q;
      tgl_r_q  <= tgl_q;
      word_q   <= word_d;
      wvalid_q <= wvalid_d;
    end
  end

  // --------------------------------------------------------------------------
  // Pin direction and ownership
  // --------------------------------------------------------------------------
  ccdp_pin_drv_t clk_drv, d0_drv, d1_drv;
  logic          self_t;

  assign self_t = is_self_timed(scheme_q);

  always_comb
  begin
    clk_drv = '{o: CCDP_CLK_IDLE, oe: 1'b0};
    d0_drv  = '{o: 1'b0, oe: 1'b0};
    d1_drv  = '{o: 1'b0, oe: 1'b0};
    case (phase_q)
      CCDP_LOAD:
      begin
        if (self_t)
          clk_drv = '{o: gen_clk_q, oe: 1'b1};
        if (scheme_q == CCDP_SELF_SER)
          d1_drv = '{o: serial_flash_command_out_d, oe: 1'b1};
        else
          d1_drv = '{o: 1'b0, oe: 1'b0};
      end
      CCDP_USER:
      begin
        if (self_t)
        begin
          if (clk_pin_user_en)
            clk_drv = '{o: user_clk_o, oe: user_clk_oe};
          else
            clk_drv = '{o: CCDP_CLK_IDLE, oe: 1'b1};
        end
        // Host schemes leave the clock pin a plain input.
        case (scheme_q)
          CCDP_SELF_SER:
          begin
            d1_drv = '{o: user_data_o[1], oe: 1'b1};
            // Data pin zero stays an input.
          end
          CCDP_SELF_PAR:
          begin
            d0_drv = '{o: user_data_o[0], oe: user_data_oe[0]};
            d1_drv = '{o: user_data_o[1], oe: user_data_oe[1]};
          end
          default:
          begin
            d0_drv = '{o: user_data_o[0], oe: user_data_oe[0]};
            d1_drv = '{o: user_data_o[1], oe: user_data_oe[1]};
          end
        endcase
      end
      default:
        clk_drv = '{o: CCDP_CLK_IDLE, oe: 1'b0};
    endcase
  end

  assign config_clock_pin_o      = clk_drv.o;
  assign config_clock_pin_oe     = clk_drv.oe;
  assign data_pin_o              = {d1_drv.o, d0_drv.o};
  assign data_pin_oe             = {d1_drv.oe, d0_drv.oe};
  assign user_data_i             = user_mode ? data_pin_i : 2'h0;
  assign config_complete_line_o  = 1'b0;
  assign config_complete_line_oe = (phase_q != CCDP_USER);
  assign user_mode               = (phase_q == CCDP_USER);
  assign cfg_word                = word_q;
  assign cfg_word_valid          = wvalid_q;
  assign cfg_word_is_wide        = wide_q;
  assign active_scheme           = scheme_q;

endmodule

//--- bench/ccdp_props.sv
// Checker of pin direction and completion behaviour of the loader.
`timescale 1ns/100ps
module ccdp_props
  import ccdp_pkg::*;
(
  input wire logic         clk,
  input wire logic         rst_b,
  input wire logic         clk_pin_user_en,
  input wire logic         flash_word_mode,
  input wire logic         config_clock_pin_o,
  input wire logic         config_clock_pin_oe,
  input wire logic [1:0]   data_pin_oe,
  input wire logic         config_complete_line_o,
  input wire logic         config_complete_line_oe,
  input wire logic         user_mode,
  input wire logic         cfg_word_valid,
  input wire logic         cfg_word_is_wide,
  input wire ccdp_scheme_t active_scheme
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Beats still in flight at entry are dropped by the load-window gate;
  // silence is still demanded only after eight cycles in user mode.
  sequence s_user_settled;
    user_mode [*8];
  endsequence

  a_done_low: assert property (
    !user_mode |-> config_complete_line_oe && !config_complete_line_o)
    else $error("done line released early");
  a_user_stands: assert property (
    user_mode |=> user_mode) else $error("user mode dropped");
  a_no_beat_user: assert property (
    s_user_settled |-> !cfg_word_valid) else $error("beat in user mode");
  a_host_clk_in: assert property (
    !active_scheme[1] |-> !config_clock_pin_oe)
    else $error("host clock pin driven");
  a_self_clk_out: assert property (
    cfg_word_valid && active_scheme[1] |-> config_clock_pin_oe)
    else $error("self clock not driven");
  a_clk_idle: assert property (
    user_mode && active_scheme[1] && !clk_pin_user_en
    |-> config_clock_pin_oe && config_clock_pin_o == CCDP_CLK_IDLE)
    else $error("clock pin not idle");
  a_d1_serial: assert property (
    cfg_word_valid && active_scheme == CCDP_SELF_SER |-> data_pin_oe[1])
    else $error("data pin 1 not driven");
  a_d1_host_bit: assert property (
    !user_mode && active_scheme == CCDP_HOST_BIT |-> !data_pin_oe[1])
    else $error("data pin 1 driven in load");
  a_d0_input: assert property (
    !user_mode && active_scheme != CCDP_SELF_PAR |-> !data_pin_oe[0])
    else $error("data pin 0 driven in load");
  a_beat_pulse: assert property (
    cfg_word_valid |=> !cfg_word_valid) else $error("beat flag too long");
  a_wide_word: assert property (
    cfg_word_valid && active_scheme == CCDP_SELF_PAR
    |-> cfg_word_is_wide == flash_word_mode) else $error("width flag wrong");
  a_scheme_fixed: assert property (
    cfg_word_valid |-> active_scheme == $past(active_scheme, 2))
    else $error("scheme changed in load");
endmodule

bind ccdp_top ccdp_props chk_u (.clk, .rst_b, .clk_pin_user_en,
  .flash_word_mode, .config_clock_pin_o, .config_clock_pin_oe, .data_pin_oe,
  .config_complete_line_o, .config_complete_line_oe, .user_mode,
  .cfg_word_valid, .cfg_word_is_wide, .active_scheme);

//--- bench/ccdp_feed_model.sv
// Model of the host or flash that presents data on the low pins.
`timescale 1ns/100ps
module ccdp_feed_model
(
  input  wire logic        link_clk,
  input  wire logic        frame,
  input  wire logic [15:0] pat,
  output logic [15:0]      bus
);
  logic [15:0] hold;

  initial hold = 16'h0000;
  // Data moves on the falling edge so it is steady at the capture edge.
  always @(negedge link_clk) hold <= pat;
  // Released pins show the inverse so stale data can never pass.
  assign bus = frame ? hold : ~hold;
endmodule

//--- bench/ccdp_top_bench.sv
// Self-checking bench for the configuration clock and data pins.
`timescale 1ns/100ps
module ccdp_top_bench;
  import ccdp_pkg::*;
  logic         clk = 0, rst_b = 0, hclk = 0, wmode = 0, cs_b = 1;
  logic         start = 0, ok = 0, cuen = 0, frame = 0, ucoe = 0;
  logic [1:0]   sel = 0, udo = 0, udoe = 0;
  logic [15:0]  pat = 0, mask = 0;
  logic         link, clk_o, clk_oe, done_o, done_oe, umode, valid, wide;
  logic [1:0]   dpo, dpoe, udi;
  logic [15:0]  bus, word, wsv;
  ccdp_scheme_t asch;
  int           err_total = 0, tests_run = 0, seed = 94, beats = 0, n;
  logic [15:0]  expq[$];

  always #5 clk = ~clk;
  // Self-timed schemes capture on the clock the device itself drives.
  assign link = clk_oe ? clk_o : hclk;

  ccdp_feed_model feed_u (.link_clk(link), .frame, .pat, .bus);

  ccdp_top dut_u (.clk, .rst_b, .link_clk(link), .scheme_sel(sel),
    .flash_word_mode(wmode), .chip_select_b(cs_b), .load_start(start),
    .load_ok(ok), .clk_pin_user_en(cuen), .config_clock_pin_i(link),
    .config_clock_pin_o(clk_o), .config_clock_pin_oe(clk_oe),
    .data_pin_i(bus[1:0]), .data_pin_o(dpo), .data_pin_oe(dpoe),
    .flash_bus_i(bus), .serial_flash_command_out_d(pat[0]),
    .user_clk_o(pat[1]), .user_clk_oe(ucoe), .user_data_o(udo),
    .user_data_oe(udoe), .user_data_i(udi),
    .config_complete_line_o(done_o), .config_complete_line_oe(done_oe),
    .user_mode(umode), .cfg_word(word), .cfg_word_valid(valid),
    .cfg_word_is_wide(wide), .active_scheme(asch));

  always @(negedge clk) pat <= 16'($random(seed));
  always @(posedge link)
    if (frame)
      expq.push_back(bus & mask);

  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  always @(negedge clk)
    if (valid === 1'b1)
    begin
      beats++;
      if (expq.size() > 0)
        chk("cfg_word", expq.pop_front(), word & mask);
    end

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // The host clock rests low between bursts.
  task automatic pulses(int cnt);
    repeat (cnt)
    begin
      #1.7 hclk = 1;
      #3 hclk = 0;
      #55.3;
    end
  endtask

  task automatic wait_user;
    int k;
    k = 0;
    while (umode !== 1'b1 && k < 100)
    begin
      @(negedge clk);
      k++;
    end
    if (umode !== 1'b1)
    begin
      err_total++;
      test_done();
    end
  endtask

  // Counts rising edges of the device-driven clock, sampled between edges.
  task automatic lead_in(int cnt);
    int k, r;
    logic p;
    k = 0;
    r = 0;
    p = link;
    while (r < cnt && k < 100)
    begin
      @(negedge clk);
      if (link && !p)
        r++;
      p = link;
      k++;
    end
    if (r < cnt)
    begin
      err_total++;
      test_done();
    end
  endtask

  initial
  begin
    for (int s = 0; s < 4; s++)
    begin
      @(negedge clk);
      rst_b = 0;
      ok = 0;
      start = 0;
      cs_b = 1;
      udoe = 0;
      ucoe = 0;
      expq.delete();
      sel = s[1:0];
      wmode = 1'($random(seed));
      cuen = 1'($random(seed));
      mask = (s == 0 || s == 2) ? 16'h0001 : 16'h00FF;
      if (s == 3 && wmode)
        mask = 16'hFFFF;
      // The link side needs edges inside reset as well.
      repeat (2)
      begin
        #3 hclk = 1;
        #3 hclk = 0;
      end
      #6;
      @(negedge clk);
      rst_b = 1;
      cs_b = 0;
      start = 1;
      // Two lead-in edges carry the load window over to the link side.
      repeat (4) @(negedge clk);
      if (s < 2)
        pulses(2);
      else
        lead_in(2);
      frame = 1;
      if (s < 2)
        pulses(6);
      else
        #600;
      chk("clock pin oe", s > 1, clk_oe);
      chk("data pin 1 oe", s == 2, dpoe[1]);
      chk("scheme", s, asch);
      frame = 0;
      repeat (8) @(negedge clk);
      chk("beats left", 0, expq.size());
      ok = 1;
      wait_user();
      chk("done line oe", 0, done_oe);
      if (s > 1 && !cuen)
        chk("clock idle", {1'b1, CCDP_CLK_IDLE}, {clk_oe, clk_o});
      if (s < 2)
        chk("clock pin oe", 0, clk_oe);
      udoe = 2'($random(seed));
      udo = 2'($random(seed));
      ucoe = 1'($random(seed));
      repeat (4) @(negedge clk);
      if (s > 1 && cuen)
        chk("clock released", {ucoe, pat[1]}, {clk_oe, clk_o});
      if (s != 2)
        chk("data pins oe", udoe, dpoe);
      if (s != 2)
        chk("data pins o", udo & udoe, dpo & udoe);
      if (s == 2)
        chk("data pin 1 oe", 1, dpoe[1]);
      if (s == 2)
        chk("data pin 1 o", udo[1], dpo[1]);
      if (s == 2)
        chk("data pin 0 oe", 0, dpoe[0]);
      chk("user data in", bus[1:0], udi);
      n = beats;
      wsv = word;
      if (s < 2)
      begin
        hclk = 1;
        repeat (8) @(negedge clk);
      end
      else
        pulses(3);
      chk("beats in user", 16'(n), 16'(beats));
      chk("word in user", wsv, word);
      $display("scheme %0d done", s);
    end
    test_done();
  end
endmodule
